// ### rtl/sdal_link.sv
// Top: autobaud detector, baud generator, break detect and transmitter
module sdal_link
  import sdal_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe,
  input wire sdal_drive_cfg_t driveCfg,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic baudLocked,
  output logic [BIT_CNT_W-1:0] bitClks,
  output logic breakSeen
);

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  logic syncA_q;
  logic syncB_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      syncA_q <= 1'b1;
      syncB_q <= 1'b1;
    end else begin
      syncA_q <= lineIn;
      syncB_q <= syncA_q;
    end
  end
  wire lineHigh = syncB_q;

  // ---------------------------------------------------------------
  // Autobaud detector
  // ---------------------------------------------------------------
  sdal_ab_state_t abState_q;
  sdal_ab_state_t abState_d;
  logic [BIT_CNT_W+2:0] measure_q;
  logic [BIT_CNT_W-1:0] bitClks_q;
  logic [BIT_CNT_W+3:0] lowRun_q;
  logic breakSeen_q;
  logic brkHeld_q;

  wire measureOvf = measure_q[BIT_CNT_W+2:3] > MAX_BIT_CLKS;
  wire [BIT_CNT_W-1:0] measuredBit = measure_q[BIT_CNT_W+2:3];
  // Break threshold follows the current rate, or the slowest rate when unlocked
  wire [BIT_CNT_W+3:0] breakLimit = (abState_q == SDAL_AB_LOCKED) ?
    20'(bitClks_q) * 20'(BREAK_BITS) : 20'(MAX_BIT_CLKS) * 20'(BREAK_BITS);
  // One break per low span: brkHeld_q blocks further breaks until the line goes high
  wire breakNow = !lineHigh && !brkHeld_q && (lowRun_q >= breakLimit - 20'h1);

  always_comb begin
    abState_d = abState_q;
    unique case (abState_q)
      SDAL_AB_RESET: if (lineHigh) abState_d = SDAL_AB_WAIT_LOW;
      SDAL_AB_WAIT_LOW: if (!lineHigh) abState_d = SDAL_AB_MEASURE;
      SDAL_AB_MEASURE: begin
        // The 80H low span ends at the first rising edge
        if (measureOvf) abState_d = SDAL_AB_RESET;
        else if (lineHigh) begin
          if (measuredBit >= MIN_BIT_CLKS) abState_d = SDAL_AB_LOCKED;
          else abState_d = SDAL_AB_RESET;
        end
      end
      SDAL_AB_LOCKED: ;
    endcase
    if (breakNow) abState_d = SDAL_AB_RESET;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      abState_q <= SDAL_AB_RESET;
      measure_q <= '0;
      bitClks_q <= '0;
      lowRun_q <= '0;
      breakSeen_q <= 1'b0;
      brkHeld_q <= 1'b0;
    end else begin
      abState_q <= abState_d;
      // The low clock that opens the span counts too
      measure_q <= (abState_q == SDAL_AB_MEASURE && !lineHigh) ? measure_q + 19'h1 :
                   (abState_d == SDAL_AB_MEASURE) ? 19'h1 : '0;
      if (abState_q == SDAL_AB_MEASURE && abState_d == SDAL_AB_LOCKED) bitClks_q <= measuredBit;
      else if (abState_d == SDAL_AB_RESET) bitClks_q <= '0;
      lowRun_q <= lineHigh ? '0 : ((breakNow || brkHeld_q) ? lowRun_q : lowRun_q + 20'h1);
      brkHeld_q <= lineHigh ? 1'b0 : (breakNow || brkHeld_q);
      breakSeen_q <= breakNow;
    end
  end

  assign baudLocked = (abState_q == SDAL_AB_LOCKED);
  assign bitClks = bitClks_q;
  assign breakSeen = breakSeen_q;

  // ---------------------------------------------------------------
  // Receiver, timed by the measured rate
  // ---------------------------------------------------------------
  logic rxBusy_q;
  logic [BIT_CNT_W-1:0] rxCnt_q;
  logic [3:0] rxIdx_q;
  logic [7:0] rxShift_q;
  logic [7:0] rxData_q;
  logic rxValid_q;
  logic txBusy_q;
  wire [BIT_CNT_W-1:0] halfBit = bitClks_q >> 1;
  wire rxTick = rxBusy_q && (rxCnt_q == '0);
  wire rxStart = baudLocked && !rxBusy_q && !lineHigh && !txBusy_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxBusy_q <= 1'b0;
      rxCnt_q <= '0;
      rxIdx_q <= '0;
      rxShift_q <= '0;
      rxData_q <= '0;
      rxValid_q <= 1'b0;
    end else begin
      rxValid_q <= 1'b0;
      if (!baudLocked) rxBusy_q <= 1'b0;
      else if (rxStart) begin
        rxBusy_q <= 1'b1;
        rxCnt_q <= halfBit + bitClks_q - 16'h1;
        rxIdx_q <= '0;
      end else if (rxTick) begin
        rxCnt_q <= bitClks_q - 16'h1;
        if (rxIdx_q == CHAR_BITS) begin
          rxBusy_q <= 1'b0;
          if (lineHigh) begin
            rxData_q <= rxShift_q;
            rxValid_q <= 1'b1;
          end
        end else begin
          rxShift_q <= {lineHigh, rxShift_q[7:1]};
          rxIdx_q <= rxIdx_q + 4'h1;
        end
      end else if (rxBusy_q) rxCnt_q <= rxCnt_q - 16'h1;
    end
  end
  assign rxData = rxData_q;
  assign rxValid = rxValid_q;

  // ---------------------------------------------------------------
  // Transmitter: baud generator runs at the measured rate
  // ---------------------------------------------------------------
  logic [BIT_CNT_W-1:0] txCnt_q;
  logic [3:0] txIdx_q;
  logic [9:0] txShift_q;
  wire txTick = txBusy_q && (txCnt_q == '0);
  wire txLast = txIdx_q == 4'h9;
  // Drive ends mid stop bit so the host may turn the line around
  wire txMidStop = txLast && (txCnt_q == halfBit);
  wire bitCentre = txBusy_q && (txCnt_q == halfBit);
  logic txDrive_q;
  assign txReady = baudLocked && !txBusy_q && !rxBusy_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txBusy_q <= 1'b0;
      txCnt_q <= '0;
      txIdx_q <= '0;
      txShift_q <= '1;
      txDrive_q <= 1'b0;
    end else begin
      if (!baudLocked) begin
        txBusy_q <= 1'b0;
        txDrive_q <= 1'b0;
      end else if (txValid && txReady) begin
        txBusy_q <= 1'b1;
        txDrive_q <= 1'b1;
        txShift_q <= {1'b1, txData, 1'b0};
        txCnt_q <= bitClks_q - 16'h1;
        txIdx_q <= '0;
      end else if (txBusy_q) begin
        if (txMidStop) txDrive_q <= 1'b0;
        if (txTick) begin
          txCnt_q <= bitClks_q - 16'h1;
          if (txLast) txBusy_q <= 1'b0;
          else begin
            txShift_q <= {1'b1, txShift_q[9:1]};
            txIdx_q <= txIdx_q + 4'h1;
          end
        end else txCnt_q <= txCnt_q - 16'h1;
      end
    end
  end

  sdal_pin_t pin;
  sdal_pin_driver sdal_pin_driver_inst (
    .core_clk(core_clk),
    .rst(rst),
    .cfg(driveCfg),
    .txActive(txDrive_q),
    .txBit(txShift_q[0]),
    .bitCentre(bitCentre),
    .lineHigh(lineHigh),
    .pin(pin)
  );
  assign lineOut = pin.out;
  assign lineOe = pin.oe;

  a_break_reset: assert property (@(posedge core_clk) disable iff (rst)
    breakNow |=> abState_q == SDAL_AB_RESET && !baudLocked)
    else $error("break did not reset autobaud");
  a_break_once: assert property (@(posedge core_clk) disable iff (rst)
    breakSeen_q |=> !breakSeen_q)
    else $error("break pulse longer than one clock");
  a_ovf_reset: assert property (@(posedge core_clk) disable iff (rst)
    abState_q == SDAL_AB_MEASURE && measureOvf |=> !baudLocked)
    else $error("overflowed measurement locked a rate");
  a_rate_range: assert property (@(posedge core_clk) disable iff (rst)
    baudLocked |-> bitClks_q >= MIN_BIT_CLKS && bitClks_q <= MAX_BIT_CLKS)
    else $error("locked bit time out of range");
  a_full_drive: assert property (@(posedge core_clk) disable iff (rst)
    driveCfg.fullDrive && !driveCfg.driveHighAssist && txDrive_q |-> lineOe)
    else $error("full drive released line while sending");
  a_start_drive: assert property (@(posedge core_clk) disable iff (rst)
    txValid && txReady |=> txDrive_q && lineOe && !lineOut)
    else $error("start bit not driven low");

endmodule

// ### rtl/sdal_pin_driver.sv
// Output driver of the debug line: open drain with optional full high drive or high assist
module sdal_pin_driver
  import sdal_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire sdal_drive_cfg_t cfg,
  input wire logic txActive,
  input wire logic txBit,
  input wire logic bitCentre,
  input wire logic lineHigh,
  output sdal_pin_t pin
);

  logic prevBit_q;
  logic assistOn_q;
  logic assistOn_d;
  wire rise = txActive && txBit && !prevBit_q;
  wire bothSet = cfg.fullDrive && cfg.driveHighAssist;

  // Assist stays on from a rise until the line reads high or centre
  assign assistOn_d = rise ? 1'b1 : ((lineHigh || bitCentre || !txActive) ? 1'b0 : assistOn_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prevBit_q <= 1'b1;
      assistOn_q <= 1'b0;
    end else begin
      prevBit_q <= txActive ? txBit : 1'b1;
      assistOn_q <= assistOn_d;
    end
  end

  wire driveLow = txActive && !txBit;
  wire driveHigh = !txActive || !txBit ? 1'b0 :
                   bothSet ? rise :
                   cfg.fullDrive ? 1'b1 :
                   cfg.driveHighAssist ? (rise || (assistOn_q && !lineHigh && !bitCentre)) :
                   1'b0;

  assign pin.oe = driveLow || driveHigh;
  assign pin.out = driveHigh;

  a_both_pulse: assert property (@(posedge core_clk) disable iff (rst)
    bothSet && pin.oe && pin.out |=> !(pin.oe && pin.out))
    else $error("high pulse longer than one clock");
  a_plain_release: assert property (@(posedge core_clk) disable iff (rst)
    !cfg.fullDrive && !cfg.driveHighAssist |-> !(pin.oe && pin.out))
    else $error("line driven high without drive control");

endmodule

// ### rtl/sdal_pkg.sv
// Package: constants and types for the serial debug autobaud link
package sdal_pkg;

  // ---------------------------------------------------------------
  // Timing and rate limits
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int BIT_CNT_W = 16;
  // Bit time limits in system clocks
  localparam logic [BIT_CNT_W-1:0] MIN_BIT_CLKS = 16'h0008;
  localparam logic [BIT_CNT_W-1:0] MAX_BIT_CLKS = 16'h0200;
  // Bit times of low line that make a break
  localparam logic [3:0] BREAK_BITS = 4'ha;
  // 80H low span is start plus seven zeros: eight bit times
  localparam logic [3:0] AUTOBAUD_LOW_BITS = 4'h8;
  localparam logic [3:0] CHAR_BITS = 4'h8;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SDAL_AB_RESET = 2'b00,
    SDAL_AB_WAIT_LOW = 2'b01,
    SDAL_AB_MEASURE = 2'b10,
    SDAL_AB_LOCKED = 2'b11
  } sdal_ab_state_t;

  typedef struct packed {
    logic fullDrive;
    logic driveHighAssist;
  } sdal_drive_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
  } sdal_pin_t;

endpackage

// ### test/sdal_host_model.sv
// Debug host model: pulls the single wire low, released otherwise
module sdal_host_model (
  input wire logic core_clk,
  output logic hostLow
);
  timeunit 1ns;
  timeprecision 1ns;
  initial hostLow = 1'b0;
  task automatic holdLow(input int n);
    hostLow = 1'b1;
    repeat (n) @(negedge core_clk);
    hostLow = 1'b0;
  endtask
  // Bit time stays within clk/512..clk/8 except where a test means a refusal
  task automatic sendChar(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      hostLow = ~f[k];
      repeat (bt) @(negedge core_clk);
    end
    hostLow = 1'b0;
  endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench of the debug autobaud link
module tb_top;
  import sdal_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int bt; logic lk;} sdal_row_t;
  logic core_clk, rst, txValid, hostLow, lineOut, lineOe, txReady, rxValid, baudLocked, breakSeen;
  logic [7:0] txData, rxData, rxLast;
  logic [BIT_CNT_W-1:0] bitClks;
  sdal_drive_cfg_t driveCfg;
  int bad_count, n_checks, cyc, brkCount, rxCount, oeN, hiN, mx, run, tr;
  logic [9:0] fr, ex;
  // Last row leaves the link locked at 16 clocks per bit
  sdal_row_t rows[5] = '{'{8, 1'b1}, '{512, 1'b1}, '{7, 1'b0}, '{600, 1'b0}, '{16, 1'b1}};
  // Pull-up wins unless someone drives
  wire lineIn = (lineOe ? lineOut : 1'b1) & ~hostLow;
  sdal_link sdal_link_inst (.core_clk(core_clk), .rst(rst), .lineIn(lineIn), .lineOut(lineOut),
    .lineOe(lineOe), .driveCfg(driveCfg), .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid), .baudLocked(baudLocked), .bitClks(bitClks), .breakSeen(breakSeen));
  sdal_host_model host (.core_clk(core_clk), .hostLow(hostLow));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic relock(input int bt);
    int b0;
    b0 = brkCount;
    host.holdLow(5400);
    repeat (20) @(negedge core_clk);
    chk("breakSeen", 16'h0001, 16'(brkCount - b0));
    host.sendChar(8'h80, bt);
    repeat (30) @(negedge core_clk);
  endtask
  task automatic sendTx(input sdal_drive_cfg_t c, input logic [7:0] d);
    driveCfg = c;
    for (int w = 0; w < 500 && txReady !== 1'b1; w++) @(negedge core_clk);
    txValid = 1'b1;
    txData = d;
    @(negedge core_clk);
    txValid = 1'b0;
    {oeN, hiN, mx, run} = '0;
    for (int i = 0; i < 168; i++) begin
      if (i % 16 == 8 && i < 160) fr[i / 16] = lineIn;
      if (lineOe) oeN++;
      run = (lineOe && lineOut) ? run + 1 : 0;
      if (run > 0) hiN++;
      if (run > mx) mx = run;
      @(negedge core_clk);
    end
    ex = {1'b1, d, 1'b0};
    chk("frame", 16'(ex), 16'(fr));
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (breakSeen === 1'b1) brkCount++;
    if (rxValid === 1'b1) begin
      rxCount++;
      rxLast = rxData;
    end
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {rst, txValid, txData, driveCfg} = '0;
    rst = 1'b1;
    repeat (12) @(negedge core_clk);
    chk("lineOe", 16'h0, 16'(lineOe));
    chk("txReady", 16'h0, 16'(txReady));
    chk("baudLocked", 16'h0, 16'(baudLocked));
    rst = 1'b0;
    $display("reset test done");
    foreach (rows[r]) begin
      relock(rows[r].bt);
      chk("baudLocked", 16'(rows[r].lk), 16'(baudLocked));
      chk("bitClks", rows[r].lk ? 16'(rows[r].bt) : 16'h0, bitClks);
      $display("autobaud row %0d done", r);
    end
    sendTx(2'b00, 8'h5a);
    chk("none high", 16'h0, 16'(hiN));
    sendTx(2'b10, 8'h5a);
    chk("full drive span", 16'd152, 16'(oeN));
    sendTx(2'b01, 8'h5a);
    chk("assist run", 16'h1, 16'(mx >= 1 && mx <= 8));
    sendTx(2'b11, 8'h5a);
    tr = 0;
    for (int k = 1; k < 10; k++) tr += ex[k] & ~ex[k-1];
    chk("pulse count", 16'(tr), 16'(hiN));
    chk("pulse width", 16'h1, 16'(mx));
    $display("drive tests done");
    tr = rxCount;
    host.sendChar(8'hc3, 16);
    repeat (20) @(negedge core_clk);
    chk("rxValid", 16'h1, 16'(rxCount - tr));
    chk("rxData", 16'h00c3, 16'(rxLast));
    $display("receive test done");
    summarize();
  end
endmodule
